// File: gpil_board.sv
// Purpose: board signals on the eight pads
// Assumes: pad driven by the port where pin_oe_n low
// Notes: released pads follow the board level
`timescale 1ns/1ps
`default_nettype none
module gpil_board
(
    // port pads
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe_n,
    // board level
    input  wire logic [7:0] board_lvl,
    output logic      [7:0] pin_in
);
    assign pin_in = (pin_out & ~pin_oe_n) | (board_lvl & pin_oe_n);
endmodule
`default_nettype wire

// File: gpil_checker.sv
// Purpose: bus and pad checks on the eight-pin port
// Assumes: hready tied to hreadyout
// Notes: bound to gpil_top
`timescale 1ns/1ps
`default_nettype none
`include "gpil_defines.svh"
module gpil_checker
#(
    parameter int                N_PINS     = 8,
    parameter logic [N_PINS-1:0] HW_CAPABLE = 8'hFF
)
(
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              srst,
    // bus
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    input  wire logic              hreadyout,
    input  wire logic [31:0]       hrdata,
    input  wire logic              hresp,
    // pads and request
    input  wire logic [N_PINS-1:0] pin_oe_n,
    input  wire logic [N_PINS-1:0] hw_func_in,
    input  wire logic              irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    logic take;
    assign take = hsel && htrans[1] && hready;
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("bus response not okay");
    a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read not one wait state");
    a_write_nowait: assert property (take && hwrite |=> hreadyout)
        else $error("write stalled");
    a_rdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
        else $error("read data moved");
    a_rdata_upper: assert property (hreadyout && !$past(hreadyout) |-> hrdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    a_hw_capable: assert property ((hw_func_in & ~HW_CAPABLE) == '0)
        else $error("function input on plain pin");
    a_reset_state: assert property ($fell(srst) |-> pin_oe_n == '1 && !irq && hw_func_in == '0)
        else $error("outputs wrong after reset");
    a_mask_all: assert property (take && hwrite && haddr == {24'h0, `GPIL_OFS_MASK} ##1 hwdata[7:0] == 8'hFF
        |-> ##[1:2] !irq)
        else $error("request with all masked");
    c_read: cover property (take && !hwrite);
    c_irq: cover property ($rose(irq));
    c_mask: cover property (take && hwrite && haddr == {24'h0, `GPIL_OFS_MASK});
endmodule
bind gpil_top gpil_checker #(.N_PINS(N_PINS), .HW_CAPABLE(HW_CAPABLE)) gpil_checker_inst
(
    .sys_clk(sys_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .pin_oe_n(pin_oe_n), .hw_func_in(hw_func_in), .irq(irq)
);
`default_nettype wire

// File: gpil_defines.svh
// Purpose: register offsets and reset values of the eight-pin port
// Assumes: AHB-Lite word registers, byte addresses
// Notes:
// Behaviour
// [R1] bit n of every word is pin n; the view-select word uses bit 0 to pick the status view instead
// [R2] write-one clears chosen pending pin interrupts
// [R3] request held while any unmasked pending
// [R4] handler clears interrupt early, not last
// [R5] software masks chosen pins' interrupts
// [R6] software unmasks chosen pins' interrupts
// [R7] raw and masked status both readable
// [R8] status views give one bit per pin
// [R9] level read returns selected pins, others zero
// [R10] software ignores bits above the eighth
// [R11] digital input enable off after reset
// [R12] hardware function only on capable pins
// [R13] pin is input, output or hardware driven
// [R14] sense: falling, rising, both, low, high
// [R15] output write touches selected output pins only
// [R16] raw set by event; masked equals raw and enable
`ifndef GPIL_DEFINES_SVH
`define GPIL_DEFINES_SVH

`define GPIL_OFS_DATA     8'h00
`define GPIL_OFS_SELECT   8'h04
`define GPIL_OFS_DIR      8'h08
`define GPIL_OFS_HWCTL    8'h0C
`define GPIL_OFS_INEN     8'h10
`define GPIL_OFS_SENSE    8'h14
`define GPIL_OFS_BOTH     8'h18
`define GPIL_OFS_POL      8'h1C
`define GPIL_OFS_UNMASK   8'h20
`define GPIL_OFS_MASK     8'h24
`define GPIL_OFS_RAW      8'h28
`define GPIL_OFS_MASKED   8'h2C
`define GPIL_OFS_VIEWSEL  8'h30
`define GPIL_OFS_VIEW     8'h34

`define GPIL_RST_INEN     8'h00
`define GPIL_RST_SELECT   8'hFF
`define GPIL_RST_ZERO     8'h00

`endif

// File: gpil_detect.sv
// Purpose: per-pin interrupt event detection
// Assumes: levels already synchronised and gated by input enable
// Notes: sense=1 level, else edge; pol=1 rising/high
`timescale 1ns/1ps
`default_nettype none
module gpil_detect
#(
    parameter int N_PINS = 8
)
(
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              srst,
    // levels and configuration
    input  wire logic [N_PINS-1:0] level,
    input  wire logic [N_PINS-1:0] enabled,
    input  wire logic [N_PINS-1:0] sense,
    input  wire logic [N_PINS-1:0] both,
    input  wire logic [N_PINS-1:0] pol,
    // one-cycle or held event per pin
    output logic      [N_PINS-1:0] event_hit
);
    typedef struct packed
    {
        logic [N_PINS-1:0] prev;
    } gpil_detect_state_type;

    gpil_detect_state_type state;
    gpil_detect_state_type next_state;

    always_comb
    begin
        next_state      = state;
        next_state.prev = level;
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    for (genvar i = 0; i < N_PINS; i++)
    begin : g_pin
        logic rise;
        logic fall;
        assign rise = level[i] & ~state.prev[i];
        assign fall = ~level[i] & state.prev[i];
        // disabled inputs never trigger
        assign event_hit[i] = enabled[i] & (sense[i] ? (level[i] == pol[i]) :
                              both[i] ? (rise | fall) : pol[i] ? rise : fall); // R14
    end
endmodule
`default_nettype wire

// File: gpil_pkg.sv
// Purpose: shared types of the eight-pin port
// Assumes: nothing beyond SystemVerilog
// Notes: data-phase states of the bus slave
package gpil_pkg;

    typedef enum logic [1:0]
    {
        GPIL_PH_IDLE,
        GPIL_PH_WRITE,
        GPIL_PH_READ_WAIT,
        GPIL_PH_READ_DONE
    } gpil_phase_type;

endpackage

// File: gpil_sync.sv
// Purpose: three-stage synchroniser for the pad inputs
// Assumes: pins are asynchronous to sys_clk
// Notes: output follows once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module gpil_sync
#(
    parameter int N_PINS = 8
)
(
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              srst,
    // pads
    input  wire logic [N_PINS-1:0] pin_in,
    // synchronised level
    output logic      [N_PINS-1:0] pin_level
);
    typedef struct packed
    {
        logic [N_PINS-1:0] ff1;
        logic [N_PINS-1:0] ff2;
        logic [N_PINS-1:0] ff3;
        logic [N_PINS-1:0] stable;
    } gpil_sync_state_type;

    gpil_sync_state_type state;
    gpil_sync_state_type next_state;

    always_comb
    begin
        next_state        = state;
        next_state.ff1    = pin_in;
        next_state.ff2    = state.ff1;
        next_state.ff3    = state.ff2;
        next_state.stable = (state.ff2 & state.ff3) | (state.stable & (state.ff2 ^ state.ff3));
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign pin_level = state.stable;
endmodule
`default_nettype wire

// File: gpil_top.sv
// Purpose: eight-pin port with interrupt logic behind an AHB-Lite slave
// Assumes: single word transfers, one clock, synchronous reset
// Notes: reads take one wait state, writes none
//
// The implementer's own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "gpil_defines.svh"
module gpil_top
#(
    parameter int               N_PINS       = 8,
    parameter logic [N_PINS-1:0] HW_CAPABLE  = 8'hFF
)
(
    // clock and reset
    input  wire logic                    sys_clk,
    input  wire logic                    srst,
    // ahb-lite slave
    input  wire logic                    hsel,
    input  wire logic [31:0]             haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic [31:0]             hwdata,
    input  wire logic                    hready,
    output logic                         hreadyout,
    output logic      [31:0]             hrdata,
    output logic                         hresp,
    // pads
    input  wire logic [N_PINS-1:0]       pin_in,
    output logic      [N_PINS-1:0]       pin_out,
    output logic      [N_PINS-1:0]       pin_oe_n,
    // peripheral function side
    input  wire logic [N_PINS-1:0]       hw_func_out,
    input  wire logic [N_PINS-1:0]       hw_func_oe,
    output logic      [N_PINS-1:0]       hw_func_in,
    // request to nested_vectored_irq_controller
    output logic                         irq
);
    import gpil_pkg::*;

    if (N_PINS < 1 || N_PINS > 32)
    begin : g_bad_width
        $error("gpil_top: N_PINS must lie in 1..32");
    end

    typedef struct packed
    {
        logic [N_PINS-1:0] out_val;
        logic [N_PINS-1:0] sel;
        logic [N_PINS-1:0] dir;
        logic [N_PINS-1:0] hw;
        logic [N_PINS-1:0] inen;
        logic [N_PINS-1:0] sense;
        logic [N_PINS-1:0] both;
        logic [N_PINS-1:0] pol;
        logic [N_PINS-1:0] unmask;
        logic [N_PINS-1:0] raw;
        logic              view;
        gpil_phase_type    phase;
        logic [7:0]        addr;
        logic              addr_ok;
        logic [31:0]       rdata;
        logic [N_PINS-1:0] pin_out;
        logic [N_PINS-1:0] pin_oe_n;
        logic [N_PINS-1:0] func_in;
        logic              irq;
    } gpil_state_type;

    gpil_state_type    state;
    gpil_state_type    next_state;
    logic [N_PINS-1:0] sync_level;
    logic [N_PINS-1:0] in_level;
    logic [N_PINS-1:0] event_hit;
    logic [N_PINS-1:0] hw_eff;
    logic [N_PINS-1:0] wdata;
    logic [N_PINS-1:0] masked;
    logic              take;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    function automatic logic [31:0] widen(input logic [N_PINS-1:0] v);
        logic [31:0] w;
        w = '0;
        w[N_PINS-1:0] = v;
        widen = w;
    endfunction

    function automatic logic mapped(input logic [31:0] a);
        mapped = (a[31:8] == 24'h000000) && (a[1:0] == 2'h0) && (a[7:0] <= `GPIL_OFS_VIEW);
    endfunction

    gpil_sync #(
        .N_PINS (N_PINS)
    ) u_sync (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .pin_in    (pin_in),
        .pin_level (sync_level)
    );

    // input enable gates every path into logic
    assign in_level = sync_level & state.inen; // R11

    gpil_detect #(
        .N_PINS (N_PINS)
    ) u_detect (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .level     (in_level),
        .enabled   (state.inen),
        .sense     (state.sense),
        .both      (state.both),
        .pol       (state.pol),
        .event_hit (event_hit)
    );

    assign hw_eff = state.hw & HW_CAPABLE; // R12
    assign masked = state.raw & state.unmask; // R16
    assign wdata  = hwdata[N_PINS-1:0]; // R1
    assign take   = hsel & htrans[1] & hready;

    always_comb
    begin
        next_state = state;

        // data phase of the previous address phase
        if (state.phase == GPIL_PH_WRITE && state.addr_ok)
        begin
            unique case (1'b1)
                hit(state.addr, `GPIL_OFS_DATA):
                begin
                    for (int i = 0; i < N_PINS; i++)
                    begin
                        if (state.sel[i] & state.dir[i] & ~hw_eff[i])
                        begin
                            next_state.out_val[i] = wdata[i]; // R15
                        end
                    end
                end
                hit(state.addr, `GPIL_OFS_SELECT):  next_state.sel = wdata;
                hit(state.addr, `GPIL_OFS_DIR):     next_state.dir = wdata; // R13
                hit(state.addr, `GPIL_OFS_HWCTL):   next_state.hw = wdata; // R13
                hit(state.addr, `GPIL_OFS_INEN):    next_state.inen = wdata; // R11
                hit(state.addr, `GPIL_OFS_SENSE):   next_state.sense = wdata; // R14
                hit(state.addr, `GPIL_OFS_BOTH):    next_state.both = wdata; // R14
                hit(state.addr, `GPIL_OFS_POL):     next_state.pol = wdata; // R14
                hit(state.addr, `GPIL_OFS_UNMASK):  next_state.unmask = state.unmask | wdata; // R6
                hit(state.addr, `GPIL_OFS_MASK):    next_state.unmask = state.unmask & ~wdata; // R5
                hit(state.addr, `GPIL_OFS_RAW):     next_state.raw = state.raw & ~wdata; // R2
                hit(state.addr, `GPIL_OFS_VIEWSEL): next_state.view = hwdata[0];
                default:
                begin
                end
            endcase
        end

        // new events win over a clear in the same cycle
        next_state.raw = next_state.raw | event_hit; // R16

        // read data is built one cycle after the address phase
        if (state.phase == GPIL_PH_READ_WAIT)
        begin
            next_state.rdata = '0;
            if (state.addr_ok)
            begin
                unique case (1'b1)
                    hit(state.addr, `GPIL_OFS_DATA):    next_state.rdata = widen(in_level & state.sel); // R9
                    hit(state.addr, `GPIL_OFS_SELECT):  next_state.rdata = widen(state.sel);
                    hit(state.addr, `GPIL_OFS_DIR):     next_state.rdata = widen(state.dir);
                    hit(state.addr, `GPIL_OFS_HWCTL):   next_state.rdata = widen(hw_eff);
                    hit(state.addr, `GPIL_OFS_INEN):    next_state.rdata = widen(state.inen);
                    hit(state.addr, `GPIL_OFS_SENSE):   next_state.rdata = widen(state.sense);
                    hit(state.addr, `GPIL_OFS_BOTH):    next_state.rdata = widen(state.both);
                    hit(state.addr, `GPIL_OFS_POL):     next_state.rdata = widen(state.pol);
                    hit(state.addr, `GPIL_OFS_UNMASK):  next_state.rdata = widen(state.unmask);
                    hit(state.addr, `GPIL_OFS_MASK):    next_state.rdata = widen(state.unmask);
                    hit(state.addr, `GPIL_OFS_RAW):     next_state.rdata = widen(state.raw); // R7
                    hit(state.addr, `GPIL_OFS_MASKED):  next_state.rdata = widen(masked); // R7
                    hit(state.addr, `GPIL_OFS_VIEWSEL): next_state.rdata = {31'h00000000, state.view};
                    hit(state.addr, `GPIL_OFS_VIEW):    next_state.rdata = widen(state.view ? masked : state.raw); // R8
                    default:
                    begin
                    end
                endcase
            end
        end

        // bus phase sequencing
        unique case (state.phase)
            GPIL_PH_READ_WAIT: next_state.phase = GPIL_PH_READ_DONE;
            default:
            begin
                if (take)
                begin
                    next_state.addr    = haddr[7:0];
                    next_state.addr_ok = mapped(haddr);
                    next_state.phase   = hwrite ? GPIL_PH_WRITE : GPIL_PH_READ_WAIT;
                end
                else
                begin
                    next_state.phase = GPIL_PH_IDLE;
                end
            end
        endcase

        // pad drivers
        for (int i = 0; i < N_PINS; i++)
        begin
            if (hw_eff[i])
            begin
                next_state.pin_out[i]  = hw_func_out[i];
                next_state.pin_oe_n[i] = ~hw_func_oe[i]; // R13
            end
            else
            begin
                next_state.pin_out[i]  = next_state.out_val[i];
                next_state.pin_oe_n[i] = ~next_state.dir[i]; // R13
            end
        end
        next_state.func_in = in_level & hw_eff; // R12

        // request stays up while any unmasked bit is pending
        next_state.irq = |(next_state.raw & next_state.unmask); // R3
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            state          <= '0;
            state.sel      <= `GPIL_RST_SELECT;
            state.inen     <= `GPIL_RST_INEN; // R11
            state.pin_oe_n <= '1;
            state.phase    <= GPIL_PH_IDLE;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign hreadyout  = (state.phase != GPIL_PH_READ_WAIT);
    assign hrdata     = state.rdata;
    assign hresp      = 1'b0;
    assign pin_out    = state.pin_out;
    assign pin_oe_n   = state.pin_oe_n;
    assign hw_func_in = state.func_in;
    assign irq        = state.irq;

    logic unused_inputs;
    assign unused_inputs = ^hsize;
endmodule
`default_nettype wire

// File: gpio_port_pin_interrupt_logic_test.sv
// Purpose: self-checking bench of the eight-pin port
// Assumes: pins 0..3 carry a peripheral function, 4..7 fed by board
// Notes: registers reached by AHB-Lite single word transfers
`timescale 1ns/1ps
`default_nettype none
`include "gpil_defines.svh"
module gpio_port_pin_interrupt_logic_test;
    localparam logic [7:0] CAP = 8'h0F;
    // {sense, both, pol}: falling, rising, both, low, high
    localparam logic [2:0] MODE [5] = '{3'b000, 3'b001, 3'b010, 3'b100, 3'b101};
    logic        sys_clk, srst, hsel, hwrite, hready, irq;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [7:0]  pin_in, pin_out, pin_oe_n, hw_func_out, hw_func_oe, hw_func_in, board_lvl;
    int          num_errors;
    int          n_compared;

    gpil_top #(.N_PINS(8), .HW_CAPABLE(CAP)) gpil_top_inst
    (
        .sys_clk(sys_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
        .hrdata(hrdata), .hresp(), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .hw_func_out(hw_func_out), .hw_func_oe(hw_func_oe), .hw_func_in(hw_func_in), .irq(irq)
    );
    gpil_board gpil_board_inst
    (
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .board_lvl(board_lvl), .pin_in(pin_in)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask

    // ready and read data taken as they stand just before the edge
    task automatic wait_rdy();
        int   n;
        logic ok;
        n = 0;
        do
        begin
            @(negedge sys_clk);
            ok = hready;
            rd = hrdata;
            @(posedge sys_clk);
            n++;
        end
        while (ok !== 1'b1 && n < 20);
        if (ok !== 1'b1)
            check(32'h0, 32'h1);
    endtask

    // request line looked at mid-cycle, away from the launching edge
    task automatic chk_irq(input logic e);
        @(negedge sys_clk);
        check({31'h0, irq}, {31'h0, e});
        @(posedge sys_clk);
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check(rd, e);
    endtask

    task automatic settle();
        repeat (6) @(posedge sys_clk);
    endtask

    task automatic done(input string s);
        $display("test %s finished, mismatches so far %0d", s, num_errors);
    endtask

    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        #1000000;
        num_errors++;
        print_verdict();
    end

    initial
    begin
        num_errors = 0;
        n_compared = 0;
        srst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        hw_func_out = 8'h00;
        hw_func_oe = 8'h00;
        board_lvl = 8'hC0;
        repeat (20) @(posedge sys_clk);
        srst <= 1'b0;
        wr(8'h38, 32'hFFFFFFFF);
        for (int a = 0; a < 'h3C; a += 4)
            rchk(a[7:0], (a == 4) ? 32'h000000FF : 32'h0);
        done("reset");
        board_lvl <= 8'hA5;
        wr(`GPIL_OFS_INEN, 32'hFF);
        wr(`GPIL_OFS_SELECT, 32'h3C);
        settle();
        rchk(`GPIL_OFS_DATA, 32'h24);
        wr(`GPIL_OFS_DIR, 32'h0F);
        wr(`GPIL_OFS_SELECT, 32'h03);
        wr(`GPIL_OFS_DATA, 32'hFF);
        wr(`GPIL_OFS_SELECT, 32'hFF);
        settle();
        check({24'h0, pin_oe_n}, 32'hF0);
        rchk(`GPIL_OFS_DATA, 32'hA3);
        done("pins");
        hw_func_out <= 8'h5A;
        hw_func_oe <= 8'hFF;
        wr(`GPIL_OFS_HWCTL, 32'hFF);
        rchk(`GPIL_OFS_HWCTL, 32'h0F);
        settle();
        check({24'h0, pin_out & ~pin_oe_n}, 32'h0A);
        check({24'h0, hw_func_in}, 32'h0A);
        wr(`GPIL_OFS_HWCTL, 32'h0);
        done("function");
        for (int m = 0; m < 5; m++)
        begin
            board_lvl <= {~MODE[m][0], 7'h25};
            wr(`GPIL_OFS_SENSE, {24'h0, MODE[m][2], 7'h0});
            wr(`GPIL_OFS_BOTH, {24'h0, MODE[m][1], 7'h0});
            wr(`GPIL_OFS_POL, {24'h0, MODE[m][0], 7'h0});
            settle();
            wr(`GPIL_OFS_RAW, 32'hFF);
            rchk(`GPIL_OFS_RAW, 32'h0);
            wr(`GPIL_OFS_UNMASK, 32'h80);
            board_lvl[7] <= MODE[m][0];
            settle();
            rchk(`GPIL_OFS_RAW, 32'h80);
            chk_irq(1'b1);
            wr(`GPIL_OFS_MASK, 32'h80);
            rchk(`GPIL_OFS_MASKED, 32'h0);
            rchk(`GPIL_OFS_RAW, 32'h80);
            chk_irq(1'b0);
        end
        done("sense");
        board_lvl <= 8'h05;
        settle();
        rchk(`GPIL_OFS_RAW, 32'hA0);
        wr(`GPIL_OFS_RAW, 32'h80);
        rchk(`GPIL_OFS_RAW, 32'h20);
        wr(`GPIL_OFS_VIEWSEL, 32'h1);
        rchk(`GPIL_OFS_VIEW, 32'h0);
        wr(`GPIL_OFS_UNMASK, 32'h20);
        rchk(`GPIL_OFS_VIEW, 32'h20);
        chk_irq(1'b1);
        wr(`GPIL_OFS_VIEWSEL, 32'h0);
        rchk(`GPIL_OFS_VIEW, 32'h20);
        wr(`GPIL_OFS_MASK, 32'hFF);
        chk_irq(1'b0);
        wr(`GPIL_OFS_UNMASK, 32'h20);
        wr(`GPIL_OFS_RAW, 32'h20);
        rchk(`GPIL_OFS_MASKED, 32'h0);
        chk_irq(1'b0);
        done("clear");
        print_verdict();
    end
endmodule
`default_nettype wire
